// ### core/mme_event_counter.sv
// event-select counter for the mesh-to-memory bridge, with apb registers.
// assumes event conditions are synchronous to pclk, the uncore clock.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module mme_event_counter
    import mme_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire mme_evt_t    evt,
    output logic [CNT_W-1:0] count_value
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int NGRP = 11;

    typedef struct packed {
        logic [31:0]           ctrl;
        logic [CNT_W-1:0]      count;
        logic [CAM_FILL_W-1:0] last_inc;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  err;
    } mme_state_t;

    mme_state_t st_reg;
    mme_state_t st_next;

    logic [7:0]            code;
    logic [7:0]            umask;
    logic [7:0]            thresh;
    logic                  en;
    logic                  inv;
    logic [7:0]            grp_vec [NGRP];
    logic [NGRP-1:0]       grp_hit;
    logic [CAM_FILL_W-1:0] raw_inc;
    logic                  cnt_step;
    logic                  access;
    logic                  wr_ctrl;
    logic                  wr_count;
    logic                  mapped;

    assign code   = st_reg.ctrl[MME_CODE_LSB +: 8];
    assign umask  = st_reg.ctrl[MME_UMASK_LSB +: 8];
    assign thresh = st_reg.ctrl[MME_THRESH_LSB +: 8];
    assign en     = st_reg.ctrl[MME_EN_BIT];
    assign inv    = st_reg.ctrl[MME_INV_BIT];

    // ------------------------------------------------------------
    // unit-mask groups
    // ------------------------------------------------------------
    // group vectors, each bit at its umask position
    assign grp_vec[0]  = {6'h00, evt.ingress_bypass_event};
    assign grp_vec[1]  = {6'h00, evt.egress_bypass_event};
    assign grp_vec[2]  = evt.dir_hit_event;
    assign grp_vec[3]  = evt.dir_miss_event;
    assign grp_vec[4]  = {4'h0, evt.dir_lookup_event};
    assign grp_vec[5]  = {1'b0, evt.dir_update_event};
    // scrub reads never reach the counter
    assign grp_vec[6]  = evt.memctl_read_scrub ? 8'h00 :
                         (evt.memctl_read_event & MC_READ_VALID);
    assign grp_vec[7]  = evt.memctl_write_event & MC_WRITE_VALID;
    assign grp_vec[8]  = {6'h00, evt.header_match_event};
    assign grp_vec[9]  = {5'h00, evt.read_queue_regular_credit_cycles};
    assign grp_vec[10] = {5'h00, evt.read_queue_special_credit_cycles};

    // one masked or per group
    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        mme_mask_or #(
            .W    (8)
        ) u_or (
            .vec  (grp_vec[g]),
            .mask (umask),
            .hit  (grp_hit[g])
        );
    end

    // ------------------------------------------------------------
    // event select
    // ------------------------------------------------------------
    // raw increment for this cycle; zero when no code matches
    always_comb begin
        raw_inc = '0;
        case (code)
            EV_CYCLES:      raw_inc = 8'h01;
            EV_BYP_INGRESS: raw_inc = {7'h00, grp_hit[0]};
            EV_BYP_EGRESS:  raw_inc = {7'h00, grp_hit[1]};
            EV_CORE_SENT:   raw_inc = {7'h00, evt.core_forward_sent};
            EV_CORE_DIS:    raw_inc = {7'h00, evt.core_forward_disabled_cycles};
            EV_CORE_OVR:    raw_inc = {7'h00, evt.core_forward_overridden};
            EV_LINK_SENT:   raw_inc = {7'h00, evt.link_forward_sent};
            EV_LINK_DIS:    raw_inc = {7'h00, evt.link_forward_disabled_cycles};
            EV_LINK_NOCRED: raw_inc = {7'h00, evt.link_forward_no_credit};
            EV_LINK_OVR:    raw_inc = {7'h00, evt.link_forward_overridden};
            EV_DIR_HIT:     raw_inc = {7'h00, grp_hit[2]};
            EV_DIR_MISS:    raw_inc = {7'h00, grp_hit[3]};
            EV_DIR_LOOKUP:  raw_inc = {7'h00, grp_hit[4]};
            EV_DIR_UPDATE:  raw_inc = {7'h00, grp_hit[5]};
            EV_MC_READ:     raw_inc = {7'h00, grp_hit[6]};
            EV_MC_WRITE:    raw_inc = {7'h00, grp_hit[7]};
            EV_HDR_MATCH:   raw_inc = {7'h00, grp_hit[8]};
            EV_RQ_REGULAR:  raw_inc = {7'h00, grp_hit[9]};
            EV_RQ_SPECIAL:  raw_inc = {7'h00, grp_hit[10]};
            EV_CAM_FULL:    raw_inc = {7'h00, evt.prefetch_cam_full_cycles};
            EV_CAM_NE:      raw_inc = {7'h00, evt.prefetch_cam_nonempty_cycles};
            EV_CAM_FILL:    raw_inc = evt.prefetch_cam_fill;
            EV_CAM_PROMO:   raw_inc = {7'h00, evt.prefetch_cam_promotions};
            EV_CAM_ALLOC:   raw_inc = {7'h00, evt.prefetch_cam_allocs};
            default:        raw_inc = '0;
        endcase
    end

    // a nonzero threshold turns the count into cycles meeting it;
    // invert flips that to cycles below it, so 1 + invert = idle cycles
    assign cnt_step = inv ? (raw_inc < thresh) : (raw_inc >= thresh);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // ready is raised in the access cycle, so each transfer is two cycles
    assign access   = psel && penable && st_reg.ready;
    assign mapped   = (paddr == MME_CTRL_OFS) || (paddr == MME_COUNT_OFS) ||
                      (paddr == MME_STAT_OFS);
    assign wr_ctrl  = access && pwrite && (paddr == MME_CTRL_OFS);
    assign wr_count = access && pwrite && (paddr == MME_COUNT_OFS);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.ready = psel && !penable;
        st_next.err   = psel && !penable && !mapped;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                MME_CTRL_OFS:  st_next.rdata = st_reg.ctrl;
                MME_COUNT_OFS: st_next.rdata = 32'(st_reg.count);
                MME_STAT_OFS:  st_next.rdata = {23'h000000, en, st_reg.last_inc};
                default:       st_next.rdata = 32'h0000_0000;
            endcase
        end
        // count path; a software write to the count wins this cycle
        st_next.last_inc = en ? raw_inc : '0;
        if (en) begin
            if (thresh == 8'h00) begin
                st_next.count = st_reg.count + CNT_W'(raw_inc);
            end else begin
                st_next.count = st_reg.count + CNT_W'(cnt_step);
            end
        end
        if (wr_count) begin
            st_next.count = CNT_W'(pwdata);
        end
        // byte lanes honoured on the control word
        if (wr_ctrl) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    st_next.ctrl[b*8 +: 8] = pwdata[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.ctrl     <= MME_CTRL_RST;
            st_reg.count    <= CNT_W'(MME_COUNT_RST);
            st_reg.last_inc <= '0;
            st_reg.rdata    <= 32'h0000_0000;
            st_reg.ready    <= 1'b0;
            st_reg.err      <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign prdata      = st_reg.rdata;
    assign pready      = st_reg.ready;
    assign pslverr     = st_reg.err;
    assign count_value = st_reg.count;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_cycle_count: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_CYCLES && thresh == 8'h00 && !wr_count)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("cycle count did not step by one");

    a_egress_taken: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_BYP_EGRESS && umask == 8'h01 && thresh == 8'h00 &&
         evt.egress_bypass_event[0] && !wr_count)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("egress bypass taken not counted");

    a_ingress_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (en && !inv && code == EV_BYP_INGRESS && umask == 8'h02 &&
         !evt.ingress_bypass_event[1] && !wr_count)
        |=> $stable(st_reg.count))
        else $error("ingress bypass counted without selected condition");

    a_dir_hit: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_DIR_HIT && thresh == 8'h00 && !wr_count &&
         (evt.dir_hit_event & umask) != 8'h00)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("directory hit not counted");

    a_scrub_excluded: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_MC_READ && thresh == 8'h00 && evt.memctl_read_scrub &&
         !wr_count)
        |=> $stable(st_reg.count))
        else $error("scrub read was counted");

    a_cam_fill: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_CAM_FILL && thresh == 8'h00 && !wr_count)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'($past(evt.prefetch_cam_fill)))
        else $error("cam fill not added");

    a_no_credit: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_RQ_REGULAR && thresh == 8'h01 && inv && !wr_count &&
         (evt.read_queue_regular_credit_cycles & umask[2:0]) == 3'h0)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("cycle without credit not counted");

    a_disabled_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!en && !wr_count) |=> $stable(st_reg.count))
        else $error("count moved while disabled");

    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("no ready in access cycle");

    a_core_sent: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_CORE_SENT && thresh == 8'h00 && evt.core_forward_sent &&
         !wr_count)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("forwarded message to core not counted");

    a_link_nocred: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_LINK_NOCRED && thresh == 8'h00 &&
         evt.link_forward_no_credit && !wr_count)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("link read without credit not counted");

    a_dir_miss: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_DIR_MISS && thresh == 8'h00 && !wr_count &&
         (evt.dir_miss_event & umask) != 8'h00)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("directory miss not counted");

    a_lookup_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_DIR_LOOKUP && thresh == 8'h00 && !wr_count &&
         (evt.dir_lookup_event & umask[3:0]) == 4'h0)
        |=> $stable(st_reg.count))
        else $error("lookup counted without selected state");

    a_update_count: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_DIR_UPDATE && thresh == 8'h00 && !wr_count &&
         ({1'b0, evt.dir_update_event} & umask) != 8'h00)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("directory update not counted");

    a_write_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_MC_WRITE && thresh == 8'h00 && umask == 8'h20 &&
         !wr_count)
        |=> $stable(st_reg.count))
        else $error("unused write mask position counted");

    a_header_match: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_HDR_MATCH && thresh == 8'h00 && !wr_count &&
         (evt.header_match_event & umask[1:0]) != 2'b00)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("header match not counted");

    a_cam_full: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_CAM_FULL && thresh == 8'h00 &&
         evt.prefetch_cam_full_cycles && !wr_count)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("cam full cycle not counted");

    a_credit_cycles: assert property (@(posedge pclk) disable iff (!presetn)
        (en && code == EV_RQ_SPECIAL && thresh == 8'h00 && !wr_count &&
         (evt.read_queue_special_credit_cycles & umask[2:0]) != 3'h0)
        |=> st_reg.count == $past(st_reg.count) + CNT_W'(1))
        else $error("special credit cycle not counted");

endmodule

`default_nettype wire

// ### core/mme_mask_or.sv
// masked or-reduce of one group of sub-conditions.
// assumes the vector and mask are both indexed by unit-mask bit.
`timescale 1ns/1ps
`default_nettype none

module mme_mask_or #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] vec,
    input  wire logic [W-1:0] mask,
    output logic              hit
);
    // any selected sub-condition counts once per cycle
    assign hit = |(vec & mask);
endmodule

`default_nettype wire

// ### core/mme_pkg.sv
// package for the bridge event-select counter: register map, field
// layout, event codes and the bundle of raw event conditions.
// assumes one uncore clock shared by the event sources and the bus.
package mme_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] MME_CTRL_OFS  = 12'h000;
    localparam logic [11:0] MME_COUNT_OFS = 12'h004;
    localparam logic [11:0] MME_STAT_OFS  = 12'h008;

    // ------------------------------------------------------------
    // control word layout and reset values
    // ------------------------------------------------------------
    localparam int MME_CODE_LSB   = 0;
    localparam int MME_UMASK_LSB  = 8;
    localparam int MME_EN_BIT     = 16;
    localparam int MME_INV_BIT    = 17;
    localparam int MME_THRESH_LSB = 24;
    localparam logic [31:0] MME_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] MME_COUNT_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // event codes
    // ------------------------------------------------------------
    localparam logic [7:0] EV_CYCLES      = 8'h00;
    localparam logic [7:0] EV_BYP_INGRESS = 8'h21;
    localparam logic [7:0] EV_BYP_EGRESS  = 8'h22;
    localparam logic [7:0] EV_CORE_SENT   = 8'h23;
    localparam logic [7:0] EV_CORE_DIS    = 8'h24;
    localparam logic [7:0] EV_CORE_OVR    = 8'h25;
    localparam logic [7:0] EV_LINK_SENT   = 8'h26;
    localparam logic [7:0] EV_LINK_DIS    = 8'h27;
    localparam logic [7:0] EV_LINK_NOCRED = 8'h28;
    localparam logic [7:0] EV_LINK_OVR    = 8'h29;
    localparam logic [7:0] EV_DIR_HIT     = 8'h2A;
    localparam logic [7:0] EV_DIR_MISS    = 8'h2B;
    localparam logic [7:0] EV_DIR_LOOKUP  = 8'h2D;
    localparam logic [7:0] EV_DIR_UPDATE  = 8'h2E;
    localparam logic [7:0] EV_MC_READ     = 8'h37;
    localparam logic [7:0] EV_MC_WRITE    = 8'h38;
    localparam logic [7:0] EV_RQ_REGULAR  = 8'h43;
    localparam logic [7:0] EV_RQ_SPECIAL  = 8'h44;
    localparam logic [7:0] EV_HDR_MATCH   = 8'h4C;
    localparam logic [7:0] EV_CAM_FULL    = 8'h53;
    localparam logic [7:0] EV_CAM_NE      = 8'h54;
    localparam logic [7:0] EV_CAM_FILL    = 8'h55;
    localparam logic [7:0] EV_CAM_PROMO   = 8'h56;
    localparam logic [7:0] EV_CAM_ALLOC   = 8'h57;

    // unit masks with unused positions, held as valid-bit maps
    localparam logic [7:0] MC_READ_VALID  = 8'h17;
    localparam logic [7:0] MC_WRITE_VALID = 8'hDF;

    localparam int CAM_FILL_W = 8;

    // raw event conditions, one cycle each, vectors indexed by umask bit
    typedef struct packed {
        logic [1:0]            ingress_bypass_event;  // 0 taken, 1 not taken
        logic [1:0]            egress_bypass_event;   // 0 taken, 1 not taken
        logic                  core_forward_sent;
        logic                  core_forward_disabled_cycles;
        logic                  core_forward_overridden;
        logic                  link_forward_sent;
        logic                  link_forward_disabled_cycles;
        logic                  link_forward_no_credit;
        logic                  link_forward_overridden;
        logic [7:0]            dir_hit_event;         // dirty I S L A, clean I S L A
        logic [7:0]            dir_miss_event;
        logic [3:0]            dir_lookup_event;      // any, I, S, A
        logic [6:0]            dir_update_event;      // any, I2S I2A S2I S2A A2I A2S
        logic [7:0]            memctl_read_event;     // normal, critical, all, -, transgress
        logic                  memctl_read_scrub;     // read is an ecc scrub
        logic [7:0]            memctl_write_event;
        logic [1:0]            header_match_event;    // 0 mesh, 1 memory side
        logic                  prefetch_cam_full_cycles;
        logic                  prefetch_cam_nonempty_cycles;
        logic [CAM_FILL_W-1:0] prefetch_cam_fill;
        logic                  prefetch_cam_promotions;
        logic                  prefetch_cam_allocs;
        logic [2:0]            read_queue_regular_credit_cycles;
        logic [2:0]            read_queue_special_credit_cycles;
    } mme_evt_t;

endpackage

// ### tb/tb_top.sv
// self-checking bench for the bridge event-select counter: apb tasks,
// register checks, then one or more short counting windows per event selection.
// assumes the counter core as the only block, on one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import mme_pkg::*;
;
    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    mme_evt_t    evt;
    mme_evt_t    e;
    logic [31:0] count_value;
    logic [31:0] rd;
    logic        er;
    int          errors;
    int          checks_done;
    int          cyc;

    mme_event_counter #(.CNT_W(32)) u_mme_event_counter (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pstrb       (pstrb),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .evt         (evt),
        .count_value (count_value)
    );

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    always #10 pclk = ~pclk;

    // whole run is about five hundred cycles; the ceiling leaves wide margin
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc >= 20000) begin
            errors = errors + 1;
            results();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready and the answer are taken at the rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait length assumed; only the hang guard ends a missing answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(input logic [7:0] code, input logic [7:0] m,
                                        input logic [7:0] th = 8'h00,
                                        input logic inv = 1'b0);
        ctl = {th, 6'h00, inv, 1'b1, m, code};
    endfunction

    // program, then 7 edges of which edges 2..5 see the event pattern
    task automatic run(input logic [31:0] c, input mme_evt_t ev, input logic [31:0] exp);
        logic [31:0] a;
        apb(1'b1, MME_CTRL_OFS, c);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        a = count_value;
        @(posedge pclk);
        evt <= ev;
        repeat (4) @(posedge pclk);
        evt <= '0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk32(count_value - a, exp);
    endtask

    task automatic results();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = '0;
        pwdata      = '0;
        pstrb       = 4'hF;
        evt         = '0;
        e           = '0;
        errors      = 0;
        checks_done = 0;
        cyc         = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmapped place, read-only status, counter load
        apb(1'b0, MME_CTRL_OFS, 32'h0);
        chk32(rd, MME_CTRL_RST);
        apb(1'b0, MME_COUNT_OFS, 32'h0);
        chk32(rd, MME_COUNT_RST);
        apb(1'b0, 12'h00C, 32'h0);
        chk1(er, 1'b1);
        chk32(rd, 32'h0);
        apb(1'b1, MME_STAT_OFS, 32'hFFFF_FFFF);
        apb(1'b0, MME_STAT_OFS, 32'h0);
        chk32(rd, 32'h0);
        chk1(er, 1'b0);
        apb(1'b1, MME_COUNT_OFS, 32'h0000_1234);
        apb(1'b0, MME_COUNT_OFS, 32'h0);
        chk32(rd, 32'h0000_1234);
        chk32(count_value, 32'h0000_1234);
        apb(1'b1, MME_CTRL_OFS, 32'h0302_A52A);
        apb(1'b0, MME_CTRL_OFS, 32'h0);
        chk32(rd, 32'h0302_A52A);
        // event selection windows
        run(32'h0, e, 32'h0);
        run(ctl(EV_CYCLES, 8'h00), e, 32'h7);
        e.egress_bypass_event = 2'b01;
        run(ctl(EV_BYP_EGRESS, 8'h01), e, 32'h4);
        run(ctl(EV_BYP_EGRESS, 8'h02), e, 32'h0);
        e.egress_bypass_event = 2'b11;
        run(ctl(EV_BYP_EGRESS, 8'h03), e, 32'h4);
        e = '0;
        e.ingress_bypass_event = 2'b10;
        run(ctl(EV_BYP_INGRESS, 8'h02), e, 32'h4);
        run(ctl(EV_BYP_EGRESS, 8'h03), e, 32'h0);
        e = '0;
        e.core_forward_sent = 1'b1;
        run(ctl(EV_CORE_SENT, 8'h00), e, 32'h4);
        e = '0;
        e.core_forward_disabled_cycles = 1'b1;
        run(ctl(EV_CORE_DIS, 8'h00), e, 32'h4);
        e = '0;
        e.core_forward_overridden = 1'b1;
        run(ctl(EV_CORE_OVR, 8'h00), e, 32'h4);
        e = '0;
        e.link_forward_sent = 1'b1;
        run(ctl(EV_LINK_SENT, 8'h00), e, 32'h4);
        e = '0;
        e.link_forward_disabled_cycles = 1'b1;
        run(ctl(EV_LINK_DIS, 8'h00), e, 32'h4);
        e = '0;
        e.link_forward_no_credit = 1'b1;
        run(ctl(EV_LINK_NOCRED, 8'h00), e, 32'h4);
        e = '0;
        e.link_forward_overridden = 1'b1;
        run(ctl(EV_LINK_OVR, 8'h00), e, 32'h4);
        e = '0;
        e.dir_hit_event = 8'h80;
        run(ctl(EV_DIR_HIT, 8'h80), e, 32'h4);
        run(ctl(EV_DIR_HIT, 8'h01), e, 32'h0);
        e = '0;
        e.dir_miss_event = 8'h10;
        run(ctl(EV_DIR_MISS, 8'h10), e, 32'h4);
        e = '0;
        e.dir_lookup_event = 4'h8;
        run(ctl(EV_DIR_LOOKUP, 8'h08), e, 32'h4);
        e = '0;
        e.dir_update_event = 7'h40;
        run(ctl(EV_DIR_UPDATE, 8'h40), e, 32'h4);
        e = '0;
        e.memctl_read_event = 8'h04;
        run(ctl(EV_MC_READ, 8'h04), e, 32'h4);
        e.memctl_read_scrub = 1'b1;
        run(ctl(EV_MC_READ, 8'h04), e, 32'h0);
        e = '0;
        e.memctl_read_event = 8'h10;
        run(ctl(EV_MC_READ, 8'h10), e, 32'h4);
        e = '0;
        e.memctl_write_event = 8'h80;
        run(ctl(EV_MC_WRITE, 8'h80), e, 32'h4);
        e = '0;
        e.memctl_write_event = 8'h10;
        run(ctl(EV_MC_WRITE, 8'h10), e, 32'h4);
        // position 5 of the write mask selects nothing
        e = '0;
        e.memctl_write_event = 8'h20;
        run(ctl(EV_MC_WRITE, 8'h20), e, 32'h0);
        e = '0;
        e.header_match_event = 2'b10;
        run(ctl(EV_HDR_MATCH, 8'h02), e, 32'h4);
        e = '0;
        e.prefetch_cam_full_cycles = 1'b1;
        run(ctl(EV_CAM_FULL, 8'h00), e, 32'h4);
        e = '0;
        e.prefetch_cam_nonempty_cycles = 1'b1;
        run(ctl(EV_CAM_NE, 8'h00), e, 32'h4);
        e = '0;
        e.prefetch_cam_promotions = 1'b1;
        run(ctl(EV_CAM_PROMO, 8'h00), e, 32'h4);
        e = '0;
        e.prefetch_cam_allocs = 1'b1;
        run(ctl(EV_CAM_ALLOC, 8'h00), e, 32'h4);
        e = '0;
        e.prefetch_cam_fill = 8'h05;
        run(ctl(EV_CAM_FILL, 8'h00), e, 32'h14);
        run(ctl(EV_CAM_FILL, 8'h00, 8'h03), e, 32'h4);
        e = '0;
        e.read_queue_regular_credit_cycles = 3'b100;
        run(ctl(EV_RQ_REGULAR, 8'h04), e, 32'h4);
        e = '0;
        e.read_queue_special_credit_cycles = 3'b001;
        run(ctl(EV_RQ_SPECIAL, 8'h01), e, 32'h4);
        run(ctl(EV_RQ_SPECIAL, 8'h01, 8'h01, 1'b1), e, 32'h3);
        run(ctl(EV_RQ_SPECIAL, 8'h01, 8'h01), e, 32'h4);
        results();
    end
endmodule

`default_nettype wire
